// *** cgc_gate.sv ***
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module cgc_gate
  import cgc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic gate_input_pin,
  input wire logic other_timer_overflow,
  input wire logic comparator_one_out_synced,
  input wire logic comparator_two_out_synced,
  output logic count_enable,
  output logic irq
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] ctl_q, ctl_d;
  logic run_q, run_d;
  logic [1:0] ist_q, ist_d;
  logic [1:0] imask_q, imask_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic src_prev_q, src_prev_d;
  logic tog_q, tog_d;
  logic val_q, val_d;
  logic cen_q, cen_d;
  logic irq_q, irq_d;
  cgc_sp_t sp_q, sp_d;
  logic src_raw;
  logic src_rise;
  logic gate_pre;
  logic gate_pol;
  logic gate_act;
  logic act_edge;
  logic sp_done;
  logic wr_ok;
  logic rd_ok;
  logic hit_ctl;
  logic hit_run;
  logic hit_ist;
  logic hit_msk;
  logic hit_any;
  logic acc_new;

  function automatic logic cgc_hit(input logic [11:0] a, input logic [11:0] r);
    cgc_hit = (a == r);
  endfunction : cgc_hit

  // ----------------------------------------
  // gate path
  // ----------------------------------------
  always_comb
  begin
    case (cgc_src_t'(ctl_q[CGC_BIT_SS_LO +: 2]))
      CGC_SRC_CMP2: src_raw = comparator_two_out_synced;
      CGC_SRC_CMP1: src_raw = comparator_one_out_synced;
      CGC_SRC_TMR: src_raw = other_timer_overflow;
      CGC_SRC_PIN: src_raw = gate_input_pin;
      default: src_raw = gate_input_pin;
    endcase
    src_rise = src_raw & ~src_prev_q;
    src_prev_d = src_raw;
    // toggle flip-flop held clear unless toggle mode is on
    tog_d = ctl_q[CGC_BIT_TM] ? (tog_q ^ src_rise) : 1'b0;
    gate_pre = ctl_q[CGC_BIT_TM] ? tog_q : src_raw;
    gate_pol = ctl_q[CGC_BIT_POL] ? gate_pre : ~gate_pre;
    // val_q holds the polarised gate one cycle late, so this is its active edge
    act_edge = gate_pol & ~val_q & (sp_q == CGC_SP_WAIT);
    gate_act = ctl_q[CGC_BIT_SPM] ? (sp_q == CGC_SP_OPEN) : gate_pol;
    // status follows gate even while gating is disabled
    val_d = gate_pol;
    cen_d = run_q & (~ctl_q[CGC_BIT_GE] | gate_act);
  end

  // ----------------------------------------
  // gate registers
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      src_prev_q <= 1'b0;
      tog_q <= 1'b0;
      val_q <= 1'b0;
      cen_q <= 1'b0;
    end
    else
    begin
      src_prev_q <= src_prev_d;
      tog_q <= tog_d;
      val_q <= val_d;
      cen_q <= cen_d;
    end
  end

  // ----------------------------------------
  // single-pulse acquisition
  // ----------------------------------------
  always_comb
  begin
    sp_d = sp_q;
    sp_done = 1'b0;
    case (sp_q)
      CGC_SP_IDLE:
      begin
        if (ctl_q[CGC_BIT_SPM] & ctl_q[CGC_BIT_GO])
        begin
          sp_d = CGC_SP_WAIT;
        end
      end
      CGC_SP_WAIT:
      begin
        if (~ctl_q[CGC_BIT_SPM])
        begin
          sp_d = CGC_SP_IDLE;
        end
        else if (act_edge)
        begin
          sp_d = CGC_SP_OPEN;
        end
      end
      CGC_SP_OPEN:
      begin
        // closes when the gate leaves its active level
        if (~ctl_q[CGC_BIT_SPM] | ~gate_pol)
        begin
          sp_d = CGC_SP_IDLE;
          sp_done = ctl_q[CGC_BIT_SPM];
        end
      end
      default: sp_d = CGC_SP_IDLE;
    endcase
  end

  // ----------------------------------------
  // pulse state register
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sp_q <= CGC_SP_IDLE;
    end
    else
    begin
      sp_q <= sp_d;
    end
  end

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  always_comb
  begin
    hit_ctl = cgc_hit(paddr, CGC_ADDR_GATE_CTL);
    hit_run = cgc_hit(paddr, CGC_ADDR_CTRL);
    hit_ist = cgc_hit(paddr, CGC_ADDR_IRQ_STAT);
    hit_msk = cgc_hit(paddr, CGC_ADDR_IRQ_MASK);
    hit_any = hit_ctl | hit_run | hit_ist | hit_msk;
    // first access cycle only; pready_q blocks a second write
    acc_new = psel & penable & ~pready_q;
    wr_ok = acc_new & pwrite;
    rd_ok = psel & ~penable & ~pwrite;
  end

  always_comb
  begin
    pready_d = acc_new;
    pslverr_d = acc_new & ~hit_any;
    prdata_d = prdata_q;
    // read data taken at setup, so it is two cycles old at pready
    if (rd_ok)
    begin
      prdata_d = 32'h0000_0000;
      if (hit_ctl)
      begin
        prdata_d[7:0] = ctl_q;
        prdata_d[CGC_BIT_GO] = (sp_q != CGC_SP_IDLE) | ctl_q[CGC_BIT_GO];
        prdata_d[CGC_BIT_VAL] = val_q;
      end
      if (hit_run)
      begin
        prdata_d[CGC_BIT_RUN] = run_q;
      end
      if (hit_ist)
      begin
        prdata_d[1:0] = ist_q;
      end
      if (hit_msk)
      begin
        prdata_d[1:0] = imask_q;
      end
    end
  end

  // ----------------------------------------
  // bus response registers
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  always_comb
  begin
    ctl_d = ctl_q;
    run_d = run_q;
    imask_d = imask_q;
    ist_d = ist_q;
    if (wr_ok & pstrb[0])
    begin
      if (cgc_hit(paddr, CGC_ADDR_GATE_CTL))
      begin
        ctl_d = (pwdata[7:0] & CGC_GATE_CTL_WMASK) | (ctl_q & ~CGC_GATE_CTL_WMASK);
      end
      if (cgc_hit(paddr, CGC_ADDR_CTRL))
      begin
        run_d = pwdata[CGC_BIT_RUN];
      end
      if (cgc_hit(paddr, CGC_ADDR_IRQ_MASK))
      begin
        imask_d = pwdata[1:0];
      end
      if (cgc_hit(paddr, CGC_ADDR_IRQ_STAT))
      begin
        ist_d = ist_q & ~pwdata[1:0];
      end
    end
    // mode taken from the new value, so arming and enabling in one write works
    if (sp_done | ~ctl_d[CGC_BIT_SPM])
    begin
      ctl_d[CGC_BIT_GO] = 1'b0;
    end
    // set wins over a same-cycle clear
    if (sp_done)
    begin
      ist_d[CGC_IRQ_DONE] = 1'b1;
    end
    if (act_edge)
    begin
      ist_d[CGC_IRQ_EDGE] = 1'b1;
    end
    irq_d = |(ist_d & imask_d);
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ctl_q <= CGC_GATE_CTL_RST;
      run_q <= 1'b0;
      ist_q <= CGC_IRQ_RST;
      imask_q <= CGC_IRQ_RST;
      irq_q <= 1'b0;
    end
    else
    begin
      ctl_q <= ctl_d;
      run_q <= run_d;
      ist_q <= ist_d;
      imask_q <= imask_d;
      irq_q <= irq_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign count_enable = cen_q;
  assign irq = irq_q;

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  // writes honour byte lane 0 only, so every control field must sit in it
  if (CGC_BIT_GE > 7 || CGC_BIT_RUN > 7)
  begin : g_bad_lane
    $error("control field outside byte lane 0");
  end
  if (CGC_BIT_SS_LO + 2 > CGC_BIT_VAL)
  begin : g_bad_sel
    $error("source select overlaps gate level status");
  end
  if (CGC_BIT_VAL == CGC_BIT_GO)
  begin : g_bad_stat
    $error("armed bit and gate level status share a position");
  end
  if (CGC_GATE_CTL_WMASK[CGC_BIT_VAL] != 1'b0)
  begin : g_bad_wmask
    $error("gate level status marked writable");
  end
  if (CGC_GATE_CTL_RST[CGC_BIT_GO] != 1'b0)
  begin : g_bad_rst
    $error("armed bit set out of reset");
  end
  if (CGC_IRQ_DONE > 1 || CGC_IRQ_EDGE > 1 || CGC_IRQ_DONE == CGC_IRQ_EDGE)
  begin : g_bad_irq
    $error("interrupt status bit outside the two-bit register");
  end
  if (CGC_ADDR_CTRL[1:0] != 2'h0 || CGC_ADDR_IRQ_STAT[1:0] != 2'h0 || CGC_ADDR_IRQ_MASK[1:0] != 2'h0)
  begin : g_bad_addr
    $error("register offset not word aligned");
  end
  if ($countones(CGC_SP_IDLE | CGC_SP_WAIT | CGC_SP_OPEN) != 3)
  begin : g_bad_sp
    $error("pulse states are not one-hot and distinct");
  end
endmodule : cgc_gate

// *** cgc_gate_chk.sv ***
`timescale 1ns/10ps
module cgc_gate_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic count_enable,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence setup_s; psel && !penable; endsequence
  ready_late_a: assert property (setup_s |-> ##[1:3] pready) else $error("no pready");
  ready_once_a: assert property (pready |=> !pready) else $error("pready held");
  ready_acc_a: assert property (pready |-> psel && penable) else $error("pready idle");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
  err_unmap_a: assert property (pready && paddr > 12'h00C |-> pslverr) else $error("no pslverr");
  err_mapped_a: assert property (pready && paddr[1:0] == 2'h0 && paddr <= 12'h00C |-> !pslverr) else $error("pslverr");
  rd_upper_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper bits");
  rst_idle_a: assert property ($rose(rst_n) |-> !irq && !count_enable) else $error("busy at reset");
endmodule : cgc_gate_chk
bind cgc_gate cgc_gate_chk u_chk (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .count_enable(count_enable), .irq(irq));

// *** cgc_gate_tb.sv ***
`timescale 1ns/10ps
module cgc_gate_tb;
  import cgc_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rdat;
  logic pready;
  logic pslverr;
  logic [1:0] pick = 2'h0;
  logic lvl = 1'b0;
  logic pin, tmr, cmp1, cmp2, count_enable, irq;
  int n_mismatch = 0;
  int checked = 0;
  always #2.5 clock = ~clock;
  cgc_src_model src (.pick(pick), .lvl(lvl), .pin(pin), .tmr(tmr), .cmp1(cmp1), .cmp2(cmp2));
  cgc_gate dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr), .gate_input_pin(pin),
    .other_timer_overflow(tmr), .comparator_one_out_synced(cmp1), .comparator_two_out_synced(cmp2),
    .count_enable(count_enable), .irq(irq));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic err);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdat = prdata;
    chk("pslverr", err, pslverr);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic t_src;
    xfer(0, CGC_ADDR_GATE_CTL, 0, 0);
    chk("gate_ctl", 32'h0, rdat & 32'hFB);
    xfer(0, 12'h010, 0, 1);
    chk("unmapped", 32'h0, rdat);
    xfer(1, 12'h010, 32'hFF, 1);
    xfer(0, CGC_ADDR_GATE_CTL, 0, 0);
    chk("unmapped_write", 32'h0, rdat & 32'hFB);
    xfer(1, CGC_ADDR_CTRL, 1, 0);
    for (int i = 0; i < 16; i++)
    begin
      pick <= i[1:0];
      lvl <= i[3];
      xfer(1, CGC_ADDR_GATE_CTL, {24'h0, 1'b1, i[2], 4'h0, i[1:0]}, 0);
      repeat (3) @(posedge clock);
      chk("count_enable", i[2] == i[3], count_enable);
      xfer(0, CGC_ADDR_GATE_CTL, 0, 0);
      chk("gate_level", i[2] == i[3], rdat[2]);
    end
    xfer(1, CGC_ADDR_GATE_CTL, 32'h03, 0);
    repeat (3) @(posedge clock);
    chk("ungated", 1, count_enable);
    xfer(0, CGC_ADDR_GATE_CTL, 0, 0);
    chk("level_ungated", 0, rdat[2]);
    xfer(1, CGC_ADDR_CTRL, 0, 0);
    repeat (3) @(posedge clock);
    chk("stopped", 0, count_enable);
  endtask : t_src
  task automatic t_pulse;
    pick <= 2'h0;
    lvl <= 1'b0;
    xfer(1, CGC_ADDR_CTRL, 1, 0);
    xfer(1, CGC_ADDR_GATE_CTL, 32'hE0, 0);
    for (int k = 1; k < 6; k++)
    begin
      lvl <= 1'b1;
      repeat (3) @(posedge clock);
      lvl <= 1'b0;
      repeat (3) @(posedge clock);
      chk("toggle", k[0], count_enable);
    end
    xfer(1, CGC_ADDR_GATE_CTL, 32'hC0, 0);
    xfer(1, CGC_ADDR_GATE_CTL, 32'hE0, 0);
    repeat (3) @(posedge clock);
    chk("toggle_clear", 0, count_enable);
    xfer(1, CGC_ADDR_GATE_CTL, 32'hD8, 0);
    xfer(0, CGC_ADDR_GATE_CTL, 0, 0);
    chk("armed", 1, rdat[3]);
    lvl <= 1'b1;
    repeat (3) @(posedge clock);
    chk("open", 1, count_enable);
    lvl <= 1'b0;
    repeat (3) @(posedge clock);
    chk("shut", 0, count_enable);
    lvl <= 1'b1;
    repeat (3) @(posedge clock);
    chk("held", 0, count_enable);
    chk("irq_masked", 0, irq);
    xfer(0, CGC_ADDR_GATE_CTL, 0, 0);
    chk("done", 0, rdat[3]);
    xfer(1, CGC_ADDR_IRQ_MASK, 1, 0);
    repeat (2) @(posedge clock);
    chk("irq", 1, irq);
    xfer(0, CGC_ADDR_IRQ_STAT, 0, 0);
    chk("irq_stat", 32'h3, rdat);
    xfer(1, CGC_ADDR_IRQ_MASK, 2, 0);
    repeat (2) @(posedge clock);
    chk("irq_edge", 1, irq);
    xfer(1, CGC_ADDR_IRQ_STAT, 3, 0);
    repeat (2) @(posedge clock);
    chk("irq_clear", 0, irq);
  endtask : t_pulse
  task automatic final_report;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    t_src;
    t_pulse;
    final_report;
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    final_report;
  end
endmodule : cgc_gate_tb

// *** cgc_pkg.sv ***
package cgc_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [11:0] CGC_ADDR_GATE_CTL = 12'h000;
  localparam logic [11:0] CGC_ADDR_CTRL = 12'h004;
  localparam logic [11:0] CGC_ADDR_IRQ_STAT = 12'h008;
  localparam logic [11:0] CGC_ADDR_IRQ_MASK = 12'h00C;
  // ----------------------------------------
  // gate control fields
  // ----------------------------------------
  localparam int CGC_BIT_GE = 7;
  localparam int CGC_BIT_POL = 6;
  localparam int CGC_BIT_TM = 5;
  localparam int CGC_BIT_SPM = 4;
  localparam int CGC_BIT_GO = 3;
  localparam int CGC_BIT_VAL = 2;
  localparam int CGC_BIT_SS_LO = 0;
  localparam int CGC_BIT_RUN = 0;
  localparam logic [7:0] CGC_GATE_CTL_RST = 8'h00;
  localparam logic [7:0] CGC_GATE_CTL_WMASK = 8'hFB;
  localparam logic [1:0] CGC_IRQ_RST = 2'h0;
  // interrupt status bits
  localparam int CGC_IRQ_DONE = 0;
  localparam int CGC_IRQ_EDGE = 1;
  // ----------------------------------------
  // gate sources
  // ----------------------------------------
  typedef enum logic [1:0] {
    CGC_SRC_PIN = 2'h0,
    CGC_SRC_TMR = 2'h1,
    CGC_SRC_CMP1 = 2'h2,
    CGC_SRC_CMP2 = 2'h3
  } cgc_src_t;
  typedef enum logic [2:0] {
    CGC_SP_IDLE = 3'b001,
    CGC_SP_WAIT = 3'b010,
    CGC_SP_OPEN = 3'b100
  } cgc_sp_t;
endpackage : cgc_pkg

// *** cgc_src_model.sv ***
`timescale 1ns/10ps
module cgc_src_model (
  input wire logic [1:0] pick,
  input wire logic lvl,
  output logic pin,
  output logic tmr,
  output logic cmp1,
  output logic cmp2
);
  // unpicked sources show the inverse, so a wrong mux choice shows
  assign pin = (pick == 2'h0) ? lvl : !lvl;
  assign tmr = (pick == 2'h1) ? lvl : !lvl;
  assign cmp1 = (pick == 2'h2) ? lvl : !lvl;
  assign cmp2 = (pick == 2'h3) ? lvl : !lvl;
endmodule : cgc_src_model
